// file: hw/msg_port_regs.vh
/*
 * Constants of the counter unit message port: parameter word offsets in the
 * setup memory image, selector codes, word counts and status bit positions.
 * Assumes the includer uses word addresses relative to the unit's setup area.
 */
`ifndef MSG_PORT_REGS_VH
`define MSG_PORT_REGS_VH

// Word offsets of message-reachable parameters.
`define OFS_OUTPUT_INTERRUPT_MASK      7'h02
`define OFS_INPUT_INTERRUPT_MASK       7'h05
`define OFS_CTR1_INDEX_RESET_MODE      7'h20
`define OFS_CTR1_MAX_COUNT             7'h21
`define OFS_CTR1_MIN_COUNT             7'h23
`define OFS_CTR1_RATE_RANGE0_DATA      7'h28
`define OFS_CTR1_RATE_RANGE1_DATA      7'h30
`define OFS_CTR1_RATE_RANGE_ENABLE     7'h38
`define OFS_CTR1_RANGE_COMPARE_ENABLE  7'h39
`define OFS_CTR2_INDEX_RESET_MODE      7'h4d
`define OFS_CTR2_MAX_COUNT             7'h4e
`define OFS_CTR2_MIN_COUNT             7'h50
`define OFS_CTR2_RATE_RANGE0_DATA      7'h55
`define OFS_CTR2_RATE_RANGE1_DATA      7'h5d
`define OFS_CTR2_RATE_RANGE_ENABLE     7'h65
`define OFS_CTR2_RANGE_COMPARE_ENABLE  7'h66

// Selector codes.
`define SEL1_GENERAL_MASK              8'h0b
`define SEL1_ENABLE                    4'hb
`define SEL1_LIMIT                     4'hc
`define SEL1_INDEX_RESET               4'he
`define SEL1_RATE_RANGE                4'hf

// Word counts of each parameter.
`define LEN_ONE                        8'h01
`define LEN_TWO                        8'h02
`define LEN_RATE_RANGE                 8'h08
`define MAX_MSG_WORDS                  8'h80

// Setup image size loaded at restart and parameter store depth.
`define INIT_WORDS                     7'h68
`define PARAM_DEPTH                    128

// Status word bit positions.
`define STAT_GLOBAL_ERROR_BIT          0
`define STAT_BUSY_BIT                  2
`define STAT_COMPLETE_BIT              3

// Write data buffer.
`define FIFO_WIDTH                     16
`define FIFO_DEPTH                     32
`define FIFO_AW                        5

`endif

// file: hw/counter_unit_message_port.v
/*
 * Message port of a two-channel counter unit, with its write-data FIFO.
 * Assumes the controller side is synchronous logic on clk: it raises a
 * one-cycle request with its operands, then streams or drains data words
 * over valid/ready, and a setup memory that answers a read one cycle later.
 */
// Functional notes
// - write code high byte, low byte select message
// - read code bytes select returned data set
// - busy bit high during message or initialisation
// - complete bit toggles after each transfer
// - global error bit set on any error
// - error during message raises instruction error
// - overlapping message fails with instruction error
// - output control bits held while busy
// - range and comparison stopped while busy
// - selectors 0B/01 and 0B/02 move masks
// - pair xC/03 moves maximum count
// - pair xC/04 moves minimum count
// - pair xB/04 moves rate range enable
// - pair xB/03 moves range/compare enable
// - setup-only parameters refused over messages
// - upper first selector digit is counter number
// - at most 128 words per message
// - restart reloads parameters from setup memory
`timescale 1ns/1ps
`include "msg_port_regs.vh"
`default_nettype none

module msg_word_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    // Clock and reset
    input  wire             clk,
    input  wire             srst,
    // Filling side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Draining side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [AW:0]      wr_ptr_q;
    reg [AW:0]      rd_ptr_q;
    wire            full;
    wire            empty;
    wire            push;
    wire            pop;

    assign full      = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
    assign empty     = (wr_ptr_q == rd_ptr_q);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign push      = in_valid && !full;
    assign pop       = out_ready && !empty;
    assign out_data  = store[rd_ptr_q[AW-1:0]];

    always @(posedge clk) begin
        if (push) begin
            store[wr_ptr_q[AW-1:0]] <= in_data;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            wr_ptr_q <= {(AW+1){1'b0}};
            rd_ptr_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end
endmodule

module counter_unit_message_port #(
    parameter [3:0] UNIT_NUMBER = 4'h0
) (
    // Clock and reset
    input  wire        clk,
    input  wire        srst,
    // Message request from the controller
    input  wire        message_write,
    input  wire        message_read,
    input  wire [7:0]  first_selector,
    input  wire [7:0]  second_selector,
    input  wire [15:0] msg_unit,
    input  wire [15:0] msg_word_count,
    // Write data words
    input  wire        wr_valid,
    output wire        wr_ready,
    input  wire [15:0] wr_data,
    // Read data words
    output reg         rd_valid,
    input  wire        rd_ready,
    output reg  [15:0] rd_data,
    // Status towards the controller
    output wire [15:0] status_word_area,
    output reg         instruction_error_flag,
    input  wire        clear_errors,
    // Setup memory reload port
    output reg  [6:0]  setup_addr,
    output reg         setup_rd,
    input  wire [15:0] setup_data,
    // Output control and counting engines
    input  wire [1:0]  gate_open_req,
    output reg  [1:0]  gate_open,
    output wire        compare_run,
    input  wire [6:0]  param_addr,
    output reg  [15:0] param_data
);
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_INIT = 2'b01;
    localparam [1:0] ST_WR   = 2'b10;
    localparam [1:0] ST_RD   = 2'b11;

    reg [15:0] param_mem [0:`PARAM_DEPTH-1];

    reg [1:0]  state_q;
    reg [1:0]  state_d;
    reg [6:0]  ptr_q;
    reg [6:0]  ptr_d;
    reg [7:0]  remain_q;
    reg [7:0]  remain_d;
    reg        complete_q;
    reg        complete_d;
    reg        gerr_q;
    reg        gerr_d;
    reg        ierr_d;
    reg        rd_valid_d;
    reg [15:0] rd_data_d;
    reg [6:0]  init_cnt_q;
    reg        init_wr_q;
    reg [6:0]  init_waddr_q;
    reg        mem_we;
    reg [6:0]  mem_waddr;
    reg [15:0] mem_wdata;

    wire        busy;
    wire        request;
    wire [15:0] dec;
    wire        dec_ok;
    wire [6:0]  dec_base;
    wire [7:0]  dec_len;
    wire        count_ok;
    wire        unit_ok;
    wire        fifo_valid;
    wire        fifo_ready;
    wire [15:0] fifo_data;

    // Selector pair decode: {ok, base offset, word count}.
    function [15:0] decode;
        input [7:0] sel1;
        input [7:0] sel2;
        reg         ok;
        reg         c2;
        reg [6:0]   b;
        reg [7:0]   n;
        begin
            ok = 1'b1;
            c2 = (sel1[7:4] == 4'h2);
            b  = 7'h00;
            n  = 8'h00;
            if (sel1 == `SEL1_GENERAL_MASK) begin
                if (sel2 == 8'h01) begin
                    b = `OFS_OUTPUT_INTERRUPT_MASK;
                    n = `LEN_TWO;
                end else if (sel2 == 8'h02) begin
                    b = `OFS_INPUT_INTERRUPT_MASK;
                    n = `LEN_ONE;
                end else begin
                    ok = 1'b0;
                end
            end else if (sel1[7:4] == 4'h1 || sel1[7:4] == 4'h2) begin
                case ({sel1[3:0], sel2})
                    {`SEL1_LIMIT, 8'h03}: begin
                        b = c2 ? `OFS_CTR2_MAX_COUNT : `OFS_CTR1_MAX_COUNT;
                        n = `LEN_TWO;
                    end
                    {`SEL1_LIMIT, 8'h04}: begin
                        b = c2 ? `OFS_CTR2_MIN_COUNT : `OFS_CTR1_MIN_COUNT;
                        n = `LEN_TWO;
                    end
                    {`SEL1_ENABLE, 8'h04}: begin
                        b = c2 ? `OFS_CTR2_RATE_RANGE_ENABLE : `OFS_CTR1_RATE_RANGE_ENABLE;
                        n = `LEN_ONE;
                    end
                    {`SEL1_ENABLE, 8'h03}: begin
                        b = c2 ? `OFS_CTR2_RANGE_COMPARE_ENABLE : `OFS_CTR1_RANGE_COMPARE_ENABLE;
                        n = `LEN_TWO;
                    end
                    {`SEL1_RATE_RANGE, 8'h02}: begin
                        b = c2 ? `OFS_CTR2_RATE_RANGE0_DATA : `OFS_CTR1_RATE_RANGE0_DATA;
                        n = `LEN_RATE_RANGE;
                    end
                    {`SEL1_RATE_RANGE, 8'h03}: begin
                        b = c2 ? `OFS_CTR2_RATE_RANGE1_DATA : `OFS_CTR1_RATE_RANGE1_DATA;
                        n = `LEN_RATE_RANGE;
                    end
                    {`SEL1_INDEX_RESET, 8'h01}: begin
                        b = c2 ? `OFS_CTR2_INDEX_RESET_MODE : `OFS_CTR1_INDEX_RESET_MODE;
                        n = `LEN_ONE;
                    end
                    default: begin
                        ok = 1'b0;
                    end
                endcase
            end else begin
                ok = 1'b0;
            end
            decode = {ok, b, n};
        end
    endfunction

    assign dec      = decode(first_selector, second_selector);
    assign dec_ok   = dec[15];
    assign dec_base = dec[14:8];
    assign dec_len  = dec[7:0];
    // The count must match the parameter exactly, so a short or long count never half-updates a word pair.
    assign count_ok = (msg_word_count <= {8'h00, `MAX_MSG_WORDS}) && (msg_word_count == {8'h00, dec_len});
    assign unit_ok  = (msg_unit == {12'h000, UNIT_NUMBER});
    assign request  = message_write || message_read;
    assign busy     = (state_q != ST_IDLE);
    assign fifo_ready = (state_q == ST_WR);
    assign compare_run = !busy;

    assign status_word_area = {12'h000, complete_q, busy, 1'b0, gerr_q};

    msg_word_fifo #(
        .WIDTH (`FIFO_WIDTH),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_wr_fifo (
        .clk       (clk),
        .srst      (srst),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .in_data   (wr_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_data)
    );

    always @* begin
        state_d    = state_q;
        ptr_d      = ptr_q;
        remain_d   = remain_q;
        complete_d = complete_q;
        gerr_d     = gerr_q;
        ierr_d     = 1'b0;
        rd_valid_d = rd_valid;
        rd_data_d  = rd_data;
        mem_we     = init_wr_q;
        mem_waddr  = init_waddr_q;
        mem_wdata  = setup_data;
        if (clear_errors) begin
            gerr_d = 1'b0;
        end
        case (state_q)
            ST_IDLE: begin
                if (message_write && message_read) begin
                    ierr_d = 1'b1;
                    gerr_d = 1'b1;
                end else if (request) begin
                    if (!dec_ok || !count_ok || !unit_ok) begin
                        ierr_d = 1'b1;
                        gerr_d = 1'b1;
                    end else if (message_write) begin
                        state_d  = ST_WR;
                        ptr_d    = dec_base;
                        remain_d = dec_len;
                    end else begin
                        state_d    = ST_RD;
                        ptr_d      = dec_base + 7'h01;
                        remain_d   = dec_len;
                        rd_valid_d = 1'b1;
                        rd_data_d  = param_mem[dec_base];
                    end
                end
            end
            ST_INIT: begin
                if (init_wr_q && init_waddr_q == `INIT_WORDS - 7'h01) begin
                    state_d = ST_IDLE;
                end
            end
            ST_WR: begin
                if (fifo_valid) begin
                    mem_we    = 1'b1;
                    mem_waddr = ptr_q;
                    mem_wdata = fifo_data;
                    ptr_d     = ptr_q + 7'h01;
                    remain_d  = remain_q - 8'h01;
                    if (remain_q == 8'h01) begin
                        state_d    = ST_IDLE;
                        complete_d = !complete_q;
                    end
                end
            end
            ST_RD: begin
                if (rd_ready) begin
                    remain_d = remain_q - 8'h01;
                    if (remain_q == 8'h01) begin
                        rd_valid_d = 1'b0;
                        state_d    = ST_IDLE;
                        complete_d = !complete_q;
                    end else begin
                        rd_data_d = param_mem[ptr_q];
                        ptr_d     = ptr_q + 7'h01;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // A request arriving while busy is refused; the running transfer carries on.
        if (busy && request) begin
            ierr_d = 1'b1;
            gerr_d = 1'b1;
        end
    end

    // Parameter store has no reset; its first 104 words are refilled from setup memory after every restart.
    always @(posedge clk) begin
        if (mem_we) begin
            param_mem[mem_waddr] <= mem_wdata;
        end
        param_data <= param_mem[param_addr];
    end

    always @(posedge clk) begin
        if (srst) begin
            state_q                <= ST_INIT;
            ptr_q                  <= 7'h00;
            remain_q               <= 8'h00;
            complete_q             <= 1'b0;
            gerr_q                 <= 1'b0;
            instruction_error_flag <= 1'b0;
            rd_valid               <= 1'b0;
            rd_data                <= 16'h0000;
            init_cnt_q             <= 7'h00;
            init_wr_q              <= 1'b0;
            init_waddr_q           <= 7'h00;
            setup_addr             <= 7'h00;
            setup_rd               <= 1'b0;
            gate_open              <= 2'b00;
        end else begin
            state_q                <= state_d;
            ptr_q                  <= ptr_d;
            remain_q               <= remain_d;
            complete_q             <= complete_d;
            gerr_q                 <= gerr_d;
            instruction_error_flag <= ierr_d;
            rd_valid               <= rd_valid_d;
            rd_data                <= rd_data_d;
            // Setup memory answers one cycle after the address, so the write trails the fetch.
            init_wr_q    <= setup_rd;
            init_waddr_q <= setup_addr;
            if (state_q == ST_INIT && init_cnt_q < `INIT_WORDS) begin
                setup_rd   <= 1'b1;
                setup_addr <= init_cnt_q;
                init_cnt_q <= init_cnt_q + 7'h01;
            end else begin
                setup_rd   <= 1'b0;
            end
            // Gate requests are sampled only when idle, so they take effect the cycle after busy falls.
            if (!busy) begin
                gate_open <= gate_open_req;
            end
        end
    end
endmodule

`default_nettype wire

// file: hw/placeholder_unused_never.v
`timescale 1ns/1ps

// file: bench/setup_mem_model.sv
/*
 * Setup memory model standing behind the message port's reload port.
 * Assumes reads are one-cycle setup_rd pulses and data is wanted one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none
module setup_mem_model (
    // Clock
    input  wire logic        clk,
    // Reload port
    input  wire logic [6:0]  setup_addr,
    input  wire logic        setup_rd,
    output var  logic [15:0] setup_data
);
    // Outside a read the bus changes every cycle, so stale data is never mistaken for a word.
    initial setup_data = 16'h0000;
    always @(posedge clk) begin
        if (setup_rd) begin
            setup_data <= {9'h0b4, setup_addr};
        end else begin
            setup_data <= ~setup_data;
        end
    end
endmodule
`default_nettype wire

// file: bench/msg_port_sva.sv
/*
 * Assertion checker for the message port top, bound from the testbench.
 * Assumes one clock domain with a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module msg_port_sva (
    // Clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // Requests and status
    input wire logic        message_write,
    input wire logic        message_read,
    input wire logic [15:0] status_word_area,
    input wire logic        instruction_error_flag,
    input wire logic        rd_valid,
    // Gate, compare and reload
    input wire logic [1:0]  gate_open_req,
    input wire logic [1:0]  gate_open,
    input wire logic        compare_run,
    input wire logic        setup_rd,
    input wire logic [6:0]  setup_addr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire busy = status_word_area[2];
    wire req_any = message_write | message_read;
    overlap_err_a: assert property (req_any && busy |=> instruction_error_flag)
        else $error("request while busy not flagged");
    both_req_a: assert property (message_write && message_read && !busy |=> instruction_error_flag && !busy)
        else $error("double request not refused");
    err_cause_a: assert property (instruction_error_flag |-> $past(req_any))
        else $error("error flag without request");
    err_bit_a: assert property (instruction_error_flag |-> status_word_area[0])
        else $error("global error bit not set");
    read_busy_a: assert property (rd_valid |-> busy)
        else $error("read data while not busy");
    init_busy_a: assert property ($fell(srst) |-> busy)
        else $error("not busy during initialisation");
    reload_start_a: assert property ($fell(srst) |-> ##[0:1] (setup_rd && setup_addr == 7'h00))
        else $error("reload did not start at word zero");
    gate_hold_a: assert property (busy |=> $stable(gate_open))
        else $error("gate changed while busy");
    gate_follow_a: assert property (!busy |=> gate_open == $past(gate_open_req))
        else $error("gate did not follow request");
    compare_stop_a: assert property (compare_run != busy)
        else $error("compare runs while busy");
    toggle_idle_a: assert property ($changed(status_word_area[3]) |-> !busy)
        else $error("complete bit toggled while busy");
endmodule
`default_nettype wire

// file: bench/testbench.sv
/*
 * Self-checking testbench of the counter unit message port.
 * Assumes the setup memory model and the bound assertion checker.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk, srst, message_write, message_read, wr_valid, rd_ready, clear_errors;
    logic [7:0]  first_selector, second_selector;
    logic [15:0] msg_unit, msg_word_count, wr_data;
    logic [1:0]  gate_open_req;
    logic [6:0]  param_addr;
    wire         wr_ready, rd_valid, instruction_error_flag, setup_rd, compare_run;
    wire  [15:0] rd_data, status_word_area, setup_data, param_data;
    wire  [6:0]  setup_addr;
    wire  [1:0]  gate_open;
    int          error_cnt = 0;
    int          checked = 0;
    logic [7:0]  s2_tab [7] = '{8'h01, 8'h03, 8'h04, 8'h02, 8'h03, 8'h04, 8'h03};
    logic [3:0]  d_tab [7] = '{4'he, 4'hc, 4'hc, 4'hf, 4'hf, 4'hb, 4'hb};
    int          len_tab [7] = '{1, 2, 2, 8, 8, 1, 2};
    logic [6:0]  ofs_tab [7] = '{7'h20, 7'h21, 7'h23, 7'h28, 7'h30, 7'h38, 7'h39};

    counter_unit_message_port counter_unit_message_port_i (.clk, .srst, .message_write, .message_read,
        .first_selector, .second_selector, .msg_unit, .msg_word_count, .wr_valid, .wr_ready, .wr_data,
        .rd_valid, .rd_ready, .rd_data, .status_word_area, .instruction_error_flag, .clear_errors,
        .setup_addr, .setup_rd, .setup_data, .gate_open_req, .gate_open, .compare_run, .param_addr, .param_data);
    setup_mem_model setup_mem_model_i (.clk, .setup_addr, .setup_rd, .setup_data);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic tick; @(posedge clk); #1; endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic req(input logic w, input logic r, input logic [7:0] s1, input logic [7:0] s2,
                       input logic [15:0] cnt, input logic [15:0] unit);
        message_write = w;
        message_read = r;
        first_selector = s1;
        second_selector = s2;
        msg_word_count = cnt;
        msg_unit = unit;
        tick;
        message_write = 1'b0;
        message_read = 1'b0;
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        while (status_word_area[2] !== 1'b0 && n < 300) begin
            tick;
            n++;
        end
        chk("busy", 16'h0000, {15'h0, status_word_area[2]});
        tick;
    endtask
    task automatic push(input logic [15:0] d);
        wr_valid = 1'b1;
        wr_data = d;
        while (wr_ready !== 1'b1) tick;
        tick;
    endtask
    task automatic chk_param(input logic [6:0] a, input logic [15:0] exp);
        param_addr = a;
        tick;
        tick;
        chk("param", exp, param_data);
    endtask
    task automatic t_reset;
        srst = 1'b1;
        tick;
        tick;
        srst = 1'b0;
        wait_idle;
        chk_param(7'h66, 16'h5a66);
        chk_param(7'h67, 16'h5a67);
        chk_param(7'h21, 16'h5a21);
        $display("reset test done");
    endtask
    task automatic t_item(input logic [7:0] s1, input logic [7:0] s2, input int len, input logic [6:0] ofs);
        logic t0;
        int   k;
        t0 = status_word_area[3];
        req(1'b1, 1'b0, s1, s2, len[15:0], 16'h0000);
        chk("flag", 16'h0000, {15'h0, instruction_error_flag});
        for (k = 0; k < len; k++) push({s1, s2} + k[15:0]);
        wr_valid = 1'b0;
        wait_idle;
        chk("done", {15'h0, ~t0}, {15'h0, status_word_area[3]});
        for (k = 0; k < len; k++) chk_param(ofs + k[6:0], {s1, s2} + k[15:0]);
        req(1'b0, 1'b1, s1, s2, len[15:0], 16'h0000);
        rd_ready = 1'b1;
        for (k = 0; k < len; k++) begin
            while (rd_valid !== 1'b1) tick;
            chk("rd_data", {s1, s2} + k[15:0], rd_data);
            tick;
        end
        rd_ready = 1'b0;
        wait_idle;
        chk("done", {15'h0, t0}, {15'h0, status_word_area[3]});
        $display("item %h%h done", s1, s2);
    endtask
    task automatic refuse(input logic w, input logic r, input logic [7:0] s1, input logic [7:0] s2,
                          input logic [15:0] cnt, input logic [15:0] unit);
        req(w, r, s1, s2, cnt, unit);
        chk("flag", 16'h0001, {15'h0, instruction_error_flag});
        chk("gerr", 16'h0001, {15'h0, status_word_area[0]});
        tick;
        chk("busy", 16'h0000, {15'h0, status_word_area[2]});
    endtask
    task automatic t_refuse;
        refuse(1'b1, 1'b0, 8'h1e, 8'h02, 16'h0001, 16'h0000);
        refuse(1'b1, 1'b0, 8'h3c, 8'h03, 16'h0002, 16'h0000);
        refuse(1'b0, 1'b1, 8'h1c, 8'h03, 16'h0001, 16'h0000);
        refuse(1'b1, 1'b0, 8'h1f, 8'h02, 16'h0081, 16'h0000);
        refuse(1'b1, 1'b0, 8'h1c, 8'h03, 16'h0002, 16'h0001);
        refuse(1'b1, 1'b1, 8'h1c, 8'h03, 16'h0002, 16'h0000);
        clear_errors = 1'b1;
        tick;
        clear_errors = 1'b0;
        tick;
        chk("gerr", 16'h0000, {15'h0, status_word_area[0]});
        $display("refusal test done");
    endtask
    task automatic t_overlap;
        req(1'b1, 1'b0, 8'h1e, 8'h01, 16'h0001, 16'h0000);
        gate_open_req = 2'b11;
        tick;
        tick;
        chk("gate", 16'h0000, {14'h0, gate_open});
        chk("run", 16'h0000, {15'h0, compare_run});
        req(1'b0, 1'b1, 8'h0b, 8'h02, 16'h0001, 16'h0000);
        chk("flag", 16'h0001, {15'h0, instruction_error_flag});
        chk("gerr", 16'h0001, {15'h0, status_word_area[0]});
        push(16'h00a5);
        wr_valid = 1'b0;
        wait_idle;
        chk("gate", 16'h0003, {14'h0, gate_open});
        chk("run", 16'h0001, {15'h0, compare_run});
        chk_param(7'h20, 16'h00a5);
        $display("overlap test done");
    endtask

    initial begin
        {message_write, message_read, wr_valid, rd_ready, clear_errors} = 5'h00;
        {first_selector, second_selector, msg_unit, msg_word_count, wr_data} = 64'h0;
        gate_open_req = 2'b00;
        param_addr = 7'h00;
        t_reset;
        t_item(8'h0b, 8'h01, 2, 7'h02);
        t_item(8'h0b, 8'h02, 1, 7'h05);
        for (int c = 0; c < 2; c++) begin
            for (int i = 0; i < 7; i++) begin
                t_item({c[0] ? 4'h2 : 4'h1, d_tab[i]}, s2_tab[i], len_tab[i],
                       ofs_tab[i] + (c[0] ? 7'h2d : 7'h00));
            end
        end
        t_refuse;
        t_overlap;
        t_reset;
        final_report;
    end

    initial begin
        #(8000 * 100);
        error_cnt++;
        $display("BAD watchdog expected done seen timeout");
        final_report;
    end
endmodule

bind counter_unit_message_port msg_port_sva msg_port_sva_i (.clk, .srst, .message_write, .message_read,
    .status_word_area, .instruction_error_flag, .rd_valid, .gate_open_req, .gate_open, .compare_run,
    .setup_rd, .setup_addr);
`default_nettype wire
